// [hw/pix_skid_buffer.sv]
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module pix_skid_buffer #(
    parameter int WIDTH = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // ready and valid come from the occupancy register; full stalls the source honestly
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            o_ready <= 1'b1;
            o_valid <= 1'b0;
        end else begin
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            o_ready <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h2;
            o_valid <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h0;
        end
    end

    // storage has no reset; only written words are ever shown
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= i_data;
        end
    end

    // registered read data: head word after the pop/push of this cycle
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_data <= '0;
        end else if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
            o_data <= i_data;
        end else begin
            o_data <= pop ? mem_r[~rp_r] : mem_r[rp_r];
        end
    end
endmodule // pix_skid_buffer

// [hw/pixel_bit_window_shifter.sv]
/*
 * per-pixel digital shift stage: selects a bit window of a 12 bit converter sample,
 * saturates on overflow, and hands the result to a two-entry output buffer.
 * assumes samples synchronous to i_clk_sys and a static shift/format setting per frame.
 */
// Functional notes
// - 8 bit format, shift 1: output sample bits 10..3.
// - 8 bit format, shift 2: output sample bits 9..2.
// - 8 bit format, shift 3: output sample bits 8..1.
// - 8 bit format, shift 4: output sample bits 7..0.
// - any set bit above the chosen window forces all output bits to one.
// - in 12 bit format, shifts 1..4 multiply the unsaturated value by 2, 4, 8, 16.
// - shift code 0 disables shifting; 1..4 select shift by 1..4.
// - 8 bit format, no shift: output sample bits 11..4.
// - 12 bit format: bits 11-n..0 then n zeros; no shift passes all bits.
`timescale 1ns/1ps
`include "pixel_shift_defs.svh"
module pixel_bit_window_shifter
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire pixel_shift_pkg::shift_t i_shift,
    input wire pixel_shift_pkg::pix_fmt_t i_fmt,
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire pixel_shift_pkg::sample_t i_smp_data,
    output logic o_pix_valid,
    input wire logic i_pix_ready,
    output logic [`SAMPLE_W-1:0] o_pix_data
);
    import pixel_shift_pkg::*;

    // illegal codes above the maximum are treated as no shift
    function automatic shift_t legal_shift(input shift_t s);
        return (s > `SHIFT_MAX) ? `SHIFT_RST : s;
    endfunction

    // saturation test: any bit at or above position 12-n set
    function automatic logic overflow(input sample_t d, input shift_t n);
        logic [`SAMPLE_W-1:0] mask;
        mask = ~({`SAMPLE_W{1'b1}} >> n);
        return (n != 3'h0) && ((d & mask) != '0);
    endfunction

    // window select; 8 bit results sit in the low byte, upper bits zero
    function automatic sample_t window(input sample_t d, input shift_t n, input pix_fmt_t f);
        sample_t sh;
        sh = d << n;
        if (overflow(d, n)) begin
            return (f == FMT_8BIT) ? sample_t'(8'hff) : 12'hfff;
        end else if (f == FMT_8BIT) begin
            return {4'h0, sh[11:4]};
        end else begin
            return sh;
        end
    endfunction

    logic stall;
    logic buf_ready;
    logic s1_valid_r;
    sample_t s1_data_r;
    sample_t s2_data_r;
    logic s2_valid_r;
    shift_t shift_r;
    pix_fmt_t fmt_r;
    logic take;
    logic buf_push;
    logic buf_pop;
    logic buf_full_nxt;
    logic s2_valid_nxt;
    logic smp_ready_nxt;

    // a sample enters only when the source offers it and the block has promised room
    assign take = i_smp_valid && o_smp_ready;

    // mirror of the buffer's occupancy step, so the source can be told one edge ahead
    assign buf_push = s2_valid_r && buf_ready;
    assign buf_pop = o_pix_valid && i_pix_ready;
    assign buf_full_nxt = !buf_pop && (!buf_ready || (o_pix_valid && buf_push));
    assign s2_valid_nxt = stall ? s2_valid_r : s1_valid_r;
    // ready is a flop, so it must predict the next edge's stall exactly; a late ready drops a sample
    assign smp_ready_nxt = !(s2_valid_nxt && buf_full_nxt);

    // pipeline holds only while stage 2 has a word the buffer cannot take, so nothing is dropped
    assign stall = s2_valid_r && !buf_ready;

    // settings captured each sample so the window is applied per sample
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_r <= `SHIFT_RST;
            fmt_r <= FMT_8BIT;
        end else if (!stall) begin
            shift_r <= legal_shift(i_shift);
            fmt_r <= i_fmt;
        end
    end

    // stage 1: register the incoming sample
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_valid_r <= 1'b0;
            s1_data_r <= '0;
        end else if (!stall) begin
            s1_valid_r <= take;
            s1_data_r <= i_smp_data;
        end
    end

    // stage 2: shift and saturate
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s2_valid_r <= 1'b0;
            s2_data_r <= '0;
        end else if (!stall) begin
            s2_valid_r <= s1_valid_r;
            s2_data_r <= window(s1_data_r, shift_r, fmt_r);
        end
    end

    // source ready is registered from the predicted stall, so a sample seen with ready high is always taken
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_smp_ready <= 1'b0;
        end else begin
            o_smp_ready <= smp_ready_nxt;
        end
    end

    pix_skid_buffer #(
        .WIDTH(`SAMPLE_W)
    ) u_outbuf (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_valid(s2_valid_r),
        .o_ready(buf_ready),
        .i_data(s2_data_r),
        .o_valid(o_pix_valid),
        .i_ready(i_pix_ready),
        .o_data(o_pix_data)
    );

    // shift 1 in 8 bit mode with no overflow yields bits 10..3
    property p_win8_s1;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_8BIT && shift_r == 3'h1 && !s1_data_r[11])
            |=> s2_data_r == {4'h0, $past(s1_data_r[10:3])};
    endproperty
    a_win8_s1: assert property (p_win8_s1) else $error("8 bit shift 1 window wrong");

    property p_win8_s2;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_8BIT && shift_r == 3'h2 && s1_data_r[11:10] == 2'h0)
            |=> s2_data_r[7:0] == $past(s1_data_r[9:2]);
    endproperty
    a_win8_s2: assert property (p_win8_s2) else $error("8 bit shift 2 window wrong");

    property p_win8_s3;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_8BIT && shift_r == 3'h3 && s1_data_r[11:9] == 3'h0)
            |=> s2_data_r[7:0] == $past(s1_data_r[8:1]);
    endproperty
    a_win8_s3: assert property (p_win8_s3) else $error("8 bit shift 3 window wrong");

    property p_win8_s4;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_8BIT && shift_r == 3'h4 && s1_data_r[11:8] == 4'h0)
            |=> s2_data_r[7:0] == $past(s1_data_r[7:0]);
    endproperty
    a_win8_s4: assert property (p_win8_s4) else $error("8 bit shift 4 window wrong");

    property p_sat;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && shift_r == 3'h2 && s1_data_r[10])
            |=> (s2_data_r == 12'hfff || s2_data_r == 12'h0ff);
    endproperty
    a_sat: assert property (p_sat) else $error("overflow did not saturate");

    property p_w12;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_12BIT && shift_r == 3'h0)
            |=> s2_data_r == $past(s1_data_r);
    endproperty
    a_w12: assert property (p_w12) else $error("12 bit pass-through altered");

    property p_w8_ns;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_8BIT && shift_r == 3'h0)
            |=> s2_data_r == {4'h0, $past(s1_data_r[11:4])};
    endproperty
    a_w8_ns: assert property (p_w8_ns) else $error("8 bit unshifted window wrong");

    sequence s_enter;
        !stall && i_smp_valid && o_smp_ready;
    endsequence
    property p_lat;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_enter ##1 !stall |=> s2_valid_r;
    endproperty
    a_lat: assert property (p_lat) else $error("valid not forwarded after two cycles");

    property p_code;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && i_shift > `SHIFT_MAX) |=> shift_r == `SHIFT_RST;
    endproperty
    a_code: assert property (p_code) else $error("illegal shift code held");

    property p_scale;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_12BIT && shift_r == 3'h4 && s1_data_r[11:8] == 4'h0)
            |=> s2_data_r == 12'($past(s1_data_r) * 16);
    endproperty
    a_scale: assert property (p_scale) else $error("shift 4 did not scale by 16");

    // a promised ready must never meet a held pipeline, or the offered sample is lost
    property p_ready;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        o_smp_ready |-> !stall;
    endproperty
    a_ready: assert property (p_ready) else $error("ready given while pipeline held");

    property p_sat12;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!stall && s1_valid_r && fmt_r == FMT_12BIT && shift_r == 3'h1 && s1_data_r[11])
            |=> s2_data_r == 12'hfff;
    endproperty
    a_sat12: assert property (p_sat12) else $error("12 bit overflow did not saturate");
endmodule // pixel_bit_window_shifter

// [hw/pixel_shift_defs.svh]
/*
 * constants for the pixel bit window shifter: widths, shift codes, reset values.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef PIXEL_SHIFT_DEFS_SVH
`define PIXEL_SHIFT_DEFS_SVH
`define SAMPLE_W 12
`define PIX8_W 8
`define SHIFT_W 3
`define SHIFT_MAX 3'h4
`define SHIFT_RST 3'h0
`define PIPE_LAT 2
`endif

// [hw/pixel_shift_pkg.sv]
/*
 * types for the pixel bit window shifter.
 * assumes the defs header sits beside it.
 */
`include "pixel_shift_defs.svh"
package pixel_shift_pkg;
    typedef logic [`SAMPLE_W-1:0] sample_t;
    typedef logic [`SHIFT_W-1:0] shift_t;
    // output depth selection
    typedef enum logic {
        FMT_8BIT = 1'b0,
        FMT_12BIT = 1'b1
    } pix_fmt_t;
endpackage

// [verification/pix_sink.sv]
/* far-side pixel receiver model: drives the receiver ready line.
   assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module pix_sink (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_slow,
    output logic o_ready
);
    logic [1:0] cnt_r;
    // slow mode takes one pixel in three, so the output buffer fills and backs up
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
        end
    end
    assign o_ready = !i_slow || (cnt_r == 2'h2);
endmodule // pix_sink

// [verification/pixel_bit_window_shifter_test.sv]
/* self-checking bench for the pixel bit window shifter.
   assumes the design package and the pix_sink model are compiled first. */
`timescale 1ns/1ps
module pixel_bit_window_shifter_test;
    import pixel_shift_pkg::*;
    logic i_clk_sys, i_arst_n, i_smp_valid, o_smp_ready, o_pix_valid, pix_ready, slow;
    int n_stall = 0;
    shift_t i_shift;
    pix_fmt_t i_fmt;
    sample_t i_smp_data;
    logic [11:0] o_pix_data;
    logic [11:0] exp_q[$];
    int n_errors, comparisons;
    sample_t pat[7] = '{12'h0b7, 12'h0ff, 12'h100, 12'h7ff, 12'h800, 12'hfff, 12'h3c9};

    pixel_bit_window_shifter DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_shift(i_shift),
        .i_fmt(i_fmt), .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_smp_data(i_smp_data),
        .o_pix_valid(o_pix_valid), .i_pix_ready(pix_ready), .o_pix_data(o_pix_data));
    pix_sink sink (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_slow(slow), .o_ready(pix_ready));

    // 50 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // reference: window select, saturation on any bit above the window, 8 bit zero-extended
    function automatic logic [11:0] expect_pix(pix_fmt_t f, shift_t s, sample_t d);
        int n;
        n = (s > 3'h4) ? 0 : int'(s);
        if (n != 0 && (d >> (12 - n)) != 0) return (f == FMT_12BIT) ? 12'hfff : 12'h0ff;
        if (f == FMT_12BIT) return d << n;
        return (d << n) >> 4;
    endfunction

    // every delivered pixel is matched in order against the expectation queue
    always @(posedge i_clk_sys) begin
        if (i_arst_n && o_pix_valid === 1'b1 && pix_ready === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected pixel", 12'h1, 12'h0);
            else check("pixel", o_pix_data, exp_q.pop_front());
        end
        if (i_smp_valid === 1'b1 && o_smp_ready === 1'b0) n_stall++;
    end

    task automatic send(input sample_t d);
        int k;
        i_smp_data <= d;
        i_smp_valid <= 1'b1;
        exp_q.push_back(expect_pix(i_fmt, i_shift, d));
        k = 0;
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (o_smp_ready !== 1'b1 && k < 100);
        if (o_smp_ready !== 1'b1) check("sample taken", 12'h0, 12'h1);
    endtask

    task automatic drain();
        int k;
        i_smp_valid <= 1'b0;
        k = 0;
        while (exp_q.size() != 0 && k < 300) begin
            @(posedge i_clk_sys);
            k++;
        end
        check("queue empty", 12'(exp_q.size()), 12'h0);
    endtask

    // every format and shift code, with samples on both sides of each saturation edge
    task automatic t_modes();
        for (int f = 0; f < 2; f++) begin
            for (int s = 0; s < 8; s++) begin
                i_fmt <= pix_fmt_t'(f);
                i_shift <= shift_t'(s);
                @(posedge i_clk_sys);
                foreach (pat[i]) send(pat[i]);
                drain();
            end
        end
        $display("t_modes done");
    endtask

    // slow receiver: an unshifted pass finds the brightest reading, the deepest safe shift is
    // chosen from it, both bursts must arrive whole and in order, and backpressure must show at least once
    task automatic t_stall();
        int base;
        int n;
        sample_t d;
        sample_t brightest;
        base = n_stall;
        n = 0;
        brightest = 12'h000;
        slow <= 1'b1;
        i_fmt <= FMT_12BIT;
        for (int round = 0; round < 2; round++) begin
            i_shift <= shift_t'(n);
            @(posedge i_clk_sys);
            for (int i = 0; i < 12; i++) begin
                d = sample_t'(12'h011 * i);
                if (round == 0 && d > brightest) brightest = d;
                send(d);
            end
            drain();
            // shift k is allowed only when every unshifted reading is below 2048 >> (k - 1)
            while (round == 0 && n < 4 && brightest < (12'h800 >> n)) n++;
        end
        check("chosen shift", 12'(n), 12'h4);
        check("backpressure", 12'(n_stall > base), 12'h1);
        slow <= 1'b0;
        $display("t_stall done");
    endtask

    // reset in mid-stream drops the pipeline and the stream restarts clean
    task automatic t_reset();
        send(12'h123);
        send(12'h456);
        i_smp_valid <= 1'b0;
        i_arst_n <= 1'b0;
        @(posedge i_clk_sys);
        check("valid in reset", 12'(o_pix_valid), 12'h0);
        check("ready in reset", 12'(o_smp_ready), 12'h0);
        exp_q.delete();
        i_arst_n <= 1'b1;
        // restart at 8 bit depth and shift 4 with a reading well under the limit
        i_fmt <= FMT_8BIT;
        i_shift <= 3'h4;
        repeat (2) @(posedge i_clk_sys);
        send(12'h089);
        drain();
        $display("t_reset done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // watchdog: the tests need about 300 cycles
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_errors++;
        end_of_test();
    end

    initial begin
        n_errors = 0;
        comparisons = 0;
        i_arst_n = 1'b0;
        i_smp_valid = 1'b0;
        i_smp_data = 12'h000;
        i_shift = 3'h0;
        i_fmt = FMT_8BIT;
        slow = 1'b0;
        repeat (6) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        t_modes();
        t_stall();
        t_reset();
        end_of_test();
    end
endmodule // pixel_bit_window_shifter_test
